// ---- rtl/fspm_regs.svh ----
// Register offsets, field positions, field values and timing counts for the self-programming mode control
`ifndef FSPM_REGS_SVH
`define FSPM_REGS_SVH

// ***********************************************************************
// Register byte offsets
// ***********************************************************************
`define FSPM_OFS_MODE_CTRL    12'h000
`define FSPM_OFS_PROT_CMD     12'h004
`define FSPM_OFS_FLASH_STATUS 12'h008
`define FSPM_OFS_FLASH_CMD    12'h00C
`define FSPM_OFS_IRQ_STATUS   12'h010
`define FSPM_OFS_IRQ_MASK     12'h014
`define FSPM_OFS_FLASH_ADDR   12'h018
`define FSPM_OFS_FLASH_DATA   12'h01C
`define FSPM_OFS_CTRL         12'h020

// ***********************************************************************
// Fields and values
// ***********************************************************************
`define FSPM_MODE_SEL_BIT     0
`define FSPM_MIRROR_LSB       2
`define FSPM_MIRROR_MSB       6
`define FSPM_PERR_BIT         0
`define FSPM_PROT_KEY         8'hA5
`define FSPM_CMD_NONE         8'h00
`define FSPM_CTRL_EXT_CLK_BIT 0
`define FSPM_CTRL_HALT_BIT    1
`define FSPM_IRQ_PERR_BIT     0
`define FSPM_IRQ_DONE_BIT     1
`define FSPM_IRQ_WIDTH        2

// ***********************************************************************
// Timing
// ***********************************************************************
`define FSPM_CLK_HZ           40000000
`define FSPM_ENTRY_MAX_NS     10000
`define FSPM_ENTRY_EXTRA_CLK  2
`define FSPM_OSC_WAIT_NS      8000
`define FSPM_CLK_PERIOD_NS    25
`define FSPM_ENTRY_CYCLES     (`FSPM_ENTRY_MAX_NS / `FSPM_CLK_PERIOD_NS + `FSPM_ENTRY_EXTRA_CLK)
`define FSPM_OSC_WAIT_CYCLES  ((`FSPM_OSC_WAIT_NS + `FSPM_CLK_PERIOD_NS - 1) / `FSPM_CLK_PERIOD_NS)

`endif

// ---- rtl/fspm_pkg.sv ----
// Types for the self-programming mode control block
`default_nettype none
package fspm_pkg;

	typedef enum logic [1:0]
	{
		FSPM_PROT_IDLE,
		FSPM_PROT_KEYED,
		FSPM_PROT_FIRST,
		FSPM_PROT_SECOND
	} fspm_prot_t;

	typedef enum logic [1:0]
	{
		FSPM_RUN,
		FSPM_ENTRY_HALT,
		FSPM_OSC_WAIT,
		FSPM_OPERATE
	} fspm_phase_t;

	typedef struct packed
	{
		logic [11:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} fspm_apb_req_t;

	typedef struct packed
	{
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} fspm_apb_rsp_t;

	typedef struct packed
	{
		logic          mode_sel;
		logic [4:0]    mirror;
		logic [2:0]    flash_status;
		logic [7:0]    flash_cmd;
		logic [15:0]   flash_addr;
		logic [7:0]    flash_data;
		logic          ext_clk;
		logic [1:0]    irq_status;
		logic [1:0]    irq_mask;
		fspm_prot_t    prot;
		logic          first_val;
		fspm_phase_t   phase;
		logic [15:0]   count;
		logic          loaded;
		logic          flash_start;
		logic          standby;
		logic          irq;
		logic          halt_rel;
		fspm_apb_rsp_t rsp;
	} fspm_state_t;

endpackage : fspm_pkg
`default_nettype wire

// ---- rtl/fspm_ctrl.sv ----
// Self-programming mode control with protected mode write, entry halt timing and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "fspm_regs.svh"

module fspm_ctrl #(
	parameter int ENTRY_CYCLES = `FSPM_ENTRY_CYCLES,
	parameter int OSC_CYCLES   = `FSPM_OSC_WAIT_CYCLES
) (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic                   clk_en,
	input  wire fspm_pkg::fspm_apb_req_t apb_req,
	output var  fspm_pkg::fspm_apb_rsp_t apb_rsp,
	input  wire logic [4:0]             protect_byte,
	input  wire logic                   halt_exec,
	input  wire logic                   flash_busy,
	output logic                        self_prog_mode_select,
	output logic [7:0]                  flash_cmd,
	output logic [15:0]                 flash_addr,
	output logic [7:0]                  flash_data,
	output logic                        flash_start,
	output logic                        standby,
	output logic                        halt_release,
	output logic                        irq
);

	// ***********************************************************************
	// State and input synchronisers
	// ***********************************************************************
	fspm_pkg::fspm_state_t state_reg;
	fspm_pkg::fspm_state_t state_next;
	// The protect byte and flash busy pins cross in through two flops before any logic reads them; halt_exec is read directly
	logic [4:0]            pb_meta_reg;
	logic [4:0]            pb_sync_reg;
	logic [1:0]            busy_sync_reg;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// ***********************************************************************
	// Bus decode
	// ***********************************************************************
	logic       acc;
	logic       wr;
	logic [7:0] wd;
	logic       key_wr;
	logic       mode_wr;
	logic       busy;

	assign acc  = apb_req.psel && apb_req.penable;
	assign wr   = acc && apb_req.pwrite;
	assign wd   = apb_req.pwdata[7:0];
	assign key_wr  = wr && hit(apb_req.paddr, `FSPM_OFS_PROT_CMD);
	assign mode_wr = wr && hit(apb_req.paddr, `FSPM_OFS_MODE_CTRL);
	assign busy = busy_sync_reg[1];

	always_comb
	begin
		logic       perr_ev;
		logic       done_ev;
		logic [7:0] rd;
		logic       mapped;
		state_next = state_reg;
		perr_ev = 1'b0;
		done_ev = 1'b0;
		rd = 8'h00;
		mapped = 1'b1;
		state_next.flash_start = 1'b0;
		state_next.rsp.pready = 1'b0;
		state_next.rsp.pslverr = 1'b0;
		state_next.rsp.prdata = 32'h0000_0000;

		// Protect byte is captured once, the first enabled cycle after release
		// Later pin changes stay unseen until the next reset
		if (!state_reg.loaded)
		begin
			state_next.mirror = pb_sync_reg;
			state_next.loaded = 1'b1;
		end

		// ***********************************************************************
		// Protected write sequence; any other store in between breaks it
		// ***********************************************************************
		// The pready cycle repeats the access phase; gating on it counts each store once
		if (wr && !state_reg.rsp.pready)
		begin
			unique case (state_reg.prot)
				fspm_pkg::FSPM_PROT_IDLE:
				begin
					if (key_wr && wd == `FSPM_PROT_KEY)
						state_next.prot = fspm_pkg::FSPM_PROT_KEYED;
					else if (mode_wr)
						perr_ev = 1'b1;
				end
				fspm_pkg::FSPM_PROT_KEYED:
				begin
					if (mode_wr)
					begin
						state_next.first_val = wd[`FSPM_MODE_SEL_BIT];
						state_next.prot = fspm_pkg::FSPM_PROT_FIRST;
					end
					else
					begin
						perr_ev = 1'b1;
						state_next.prot = fspm_pkg::FSPM_PROT_IDLE;
					end
				end
				fspm_pkg::FSPM_PROT_FIRST:
				begin
					if (mode_wr && wd[`FSPM_MODE_SEL_BIT] == !state_reg.first_val)
						state_next.prot = fspm_pkg::FSPM_PROT_SECOND;
					else
					begin
						perr_ev = 1'b1;
						state_next.prot = fspm_pkg::FSPM_PROT_IDLE;
					end
				end
				fspm_pkg::FSPM_PROT_SECOND:
				begin
					state_next.prot = fspm_pkg::FSPM_PROT_IDLE;
					if (mode_wr && wd[`FSPM_MODE_SEL_BIT] == state_reg.first_val)
					begin
						// Only the fourth store lands; bits 7..1 are never written
						state_next.mode_sel = state_reg.first_val;
						if (state_reg.first_val && !state_reg.mode_sel)
						begin
							state_next.phase = fspm_pkg::FSPM_ENTRY_HALT;
							state_next.count = 16'h0000;
						end
						else if (!state_reg.first_val)
							state_next.phase = fspm_pkg::FSPM_RUN;
					end
					else
						perr_ev = 1'b1;
				end
			endcase
		end

		// ***********************************************************************
		// Halt handling and entry timing
		// ***********************************************************************
		state_next.standby = 1'b0;
		unique case (state_reg.phase)
			fspm_pkg::FSPM_RUN:
				state_next.standby = halt_exec && !state_reg.mode_sel;
			fspm_pkg::FSPM_ENTRY_HALT:
			begin
				// The entry halt ends on its own; bounded by the 10 us + 2 clock figure
				state_next.count = state_reg.count + 16'h0001;
				if (state_reg.count >= 16'(ENTRY_CYCLES - 1))
				begin
					state_next.count = 16'h0000;
					state_next.phase = state_reg.ext_clk ? fspm_pkg::FSPM_OSC_WAIT
					                                     : fspm_pkg::FSPM_OPERATE;
				end
			end
			fspm_pkg::FSPM_OSC_WAIT:
			begin
				// Hardware times the wait over OSC_CYCLES and holds off commands until it ends
				state_next.count = state_reg.count + 16'h0001;
				if (state_reg.count >= 16'(OSC_CYCLES - 1))
					state_next.phase = fspm_pkg::FSPM_OPERATE;
			end
			fspm_pkg::FSPM_OPERATE:
			begin
				// A halt while the engine is busy is dropped; firmware sees no start flag and retries
				if (halt_exec && state_reg.mode_sel && !busy)
				begin
					state_next.flash_start = 1'b1;
					done_ev = 1'b1;
				end
			end
		endcase

		// ***********************************************************************
		// APB register file, one access with one wait state per transfer
		// ***********************************************************************
		// Registers change at the edge that raises pready, one cycle before the master sees it
		if (acc && !state_reg.rsp.pready)
		begin
			state_next.rsp.pready = 1'b1;
			if (hit(apb_req.paddr, `FSPM_OFS_MODE_CTRL))
				rd = {1'b0, state_reg.mirror, 1'b0, state_reg.mode_sel};
			else if (hit(apb_req.paddr, `FSPM_OFS_PROT_CMD))
				rd = 8'h00;
			else if (hit(apb_req.paddr, `FSPM_OFS_FLASH_STATUS))
			begin
				rd = {5'b00000, state_reg.flash_status};
				if (apb_req.pwrite)
					state_next.flash_status = state_reg.flash_status & wd[2:0];
			end
			else if (hit(apb_req.paddr, `FSPM_OFS_FLASH_CMD))
			begin
				rd = state_reg.flash_cmd;
				// Only the three command bits exist; the upper bits read zero
				if (apb_req.pwrite)
					state_next.flash_cmd = {5'b00000, wd[2:0]};
			end
			else if (hit(apb_req.paddr, `FSPM_OFS_IRQ_STATUS))
			begin
				rd = {6'b000000, state_reg.irq_status};
				if (apb_req.pwrite)
					state_next.irq_status = state_reg.irq_status & ~wd[1:0];
			end
			else if (hit(apb_req.paddr, `FSPM_OFS_IRQ_MASK))
			begin
				rd = {6'b000000, state_reg.irq_mask};
				if (apb_req.pwrite)
					state_next.irq_mask = wd[1:0];
			end
			else if (hit(apb_req.paddr, `FSPM_OFS_FLASH_ADDR))
			begin
				state_next.rsp.prdata = {16'h0000, state_reg.flash_addr};
				if (apb_req.pwrite)
					state_next.flash_addr = apb_req.pwdata[15:0];
			end
			else if (hit(apb_req.paddr, `FSPM_OFS_FLASH_DATA))
			begin
				rd = state_reg.flash_data;
				if (apb_req.pwrite)
					state_next.flash_data = wd;
			end
			else if (hit(apb_req.paddr, `FSPM_OFS_CTRL))
			begin
				rd = {5'b00000, busy, state_reg.phase != fspm_pkg::FSPM_OPERATE && state_reg.mode_sel,
				      state_reg.ext_clk};
				if (apb_req.pwrite)
					state_next.ext_clk = wd[`FSPM_CTRL_EXT_CLK_BIT];
			end
			else
				mapped = 1'b0;
			if (!hit(apb_req.paddr, `FSPM_OFS_FLASH_ADDR))
				state_next.rsp.prdata = {24'h00_0000, rd};
			state_next.rsp.pslverr = !mapped;
		end

		// ***********************************************************************
		// Event flags and registered outputs
		// ***********************************************************************
		// Hardware sets win over same-cycle software clears
		if (perr_ev)
			state_next.flash_status[`FSPM_PERR_BIT] = 1'b1;
		state_next.irq_status = state_next.irq_status
		                      | {done_ev, perr_ev};
		state_next.irq = |(state_next.irq_status & state_next.irq_mask);
		// Registered so the release output is a flop rather than a decode of the phase
		state_next.halt_rel = state_next.phase == fspm_pkg::FSPM_OPERATE;
	end

	// ***********************************************************************
	// Input synchronisers
	// ***********************************************************************
	// Left out of reset so the protect byte has settled by the first cycle after release
	always_ff @(posedge clock)
	begin
		if (clk_en)
		begin
			pb_meta_reg   <= protect_byte;
			pb_sync_reg   <= pb_meta_reg;
			busy_sync_reg <= {busy_sync_reg[0], flash_busy};
		end
	end

	// ***********************************************************************
	// State register
	// ***********************************************************************
	always_ff @(posedge clock)
	begin
		if (!rstn)
			state_reg <= '0;
		else if (clk_en)
			state_reg <= state_next;
	end

	// ***********************************************************************
	// Outputs straight from flip-flops
	// ***********************************************************************
	assign apb_rsp               = state_reg.rsp;
	assign self_prog_mode_select = state_reg.mode_sel;
	assign flash_cmd             = state_reg.flash_cmd;
	assign flash_addr            = state_reg.flash_addr;
	assign flash_data            = state_reg.flash_data;
	assign flash_start           = state_reg.flash_start;
	assign standby               = state_reg.standby;
	assign halt_release          = state_reg.halt_rel;
	assign irq                   = state_reg.irq;

endmodule : fspm_ctrl
`default_nettype wire

// ---- tb/fspm_chk_checker.sv ----
// Port assertions for the self-programming mode control
`timescale 1ns/1ps
`default_nettype none
module fspm_chk (
	input wire logic                    clock,
	input wire logic                    rstn,
	input wire logic                    clk_en,
	input wire fspm_pkg::fspm_apb_req_t apb_req,
	input wire fspm_pkg::fspm_apb_rsp_t apb_rsp,
	input wire logic [4:0]              protect_byte,
	input wire logic                    halt_exec,
	input wire logic                    self_prog_mode_select,
	input wire logic                    flash_start,
	input wire logic                    standby,
	input wire logic                    halt_release
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Entry halt: held a few cycles, then released within a bound
	sequence s_low; !halt_release [*3]; endsequence
	sequence s_up; ##[1:800] halt_release; endsequence
	property p_ready; apb_req.psel && apb_req.penable && !apb_rsp.pready && clk_en |=> apb_rsp.pready; endproperty
	a_ready: assert property (p_ready) else $error("pready late");
	property p_pulse; apb_rsp.pready && clk_en |=> !apb_rsp.pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready long");
	property p_err; apb_rsp.pslverr |-> apb_rsp.pready; endproperty
	a_err: assert property (p_err) else $error("lone pslverr");
	property p_stby; halt_exec && !self_prog_mode_select |=> standby; endproperty
	a_stby: assert property (p_stby) else $error("no standby");
	property p_start; flash_start |-> $past(halt_exec) && $past(halt_release); endproperty
	a_start: assert property (p_start) else $error("stray start");
	property p_rst; $rose(rstn) |-> !self_prog_mode_select && !halt_release; endproperty
	a_rst: assert property (p_rst) else $error("mode after reset");
	property p_rel; halt_release |-> self_prog_mode_select; endproperty
	a_rel: assert property (p_rel) else $error("release in normal");
	property p_entry; $rose(self_prog_mode_select) |-> s_low ##0 s_up; endproperty
	a_entry: assert property (p_entry) else $error("entry timing");
	property p_rd;
		apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 12'h000
		|-> apb_rsp.prdata == {24'h00_0000, 1'b0, protect_byte, 1'b0, self_prog_mode_select};
	endproperty
	a_rd: assert property (p_rd) else $error("mode ctrl read");
endmodule : fspm_chk
bind fspm_ctrl fspm_chk fspm_chk_inst (.clock(clock), .rstn(rstn), .clk_en(clk_en), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .protect_byte(protect_byte), .halt_exec(halt_exec), .standby(standby),
	.self_prog_mode_select(self_prog_mode_select), .flash_start(flash_start), .halt_release(halt_release));
`default_nettype wire

// ---- tb/fspm_cpu.sv ----
// CPU firmware and flash engine model
`timescale 1ns/1ps
`default_nettype none
module fspm_cpu (
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic halt_req,
	input  wire logic mode_sel,
	input  wire logic flash_start,
	output logic      halt_exec,
	output logic      flash_busy
);
	logic       mode_q;
	logic       nop_q;
	logic [2:0] busy_cnt;
	always_ff @(posedge clock)
	begin
		mode_q <= rstn && mode_sel;
		nop_q <= rstn && mode_sel && !mode_q;
		halt_exec <= rstn && (nop_q || halt_req);
		// Engine stays busy a while so a slow answer is seen
		busy_cnt <= !rstn ? 3'h0 : flash_start ? 3'h7 : busy_cnt - {2'h0, busy_cnt != 3'h0};
	end
	assign flash_busy = busy_cnt != 3'h0;
endmodule : fspm_cpu
`default_nettype wire

// ---- tb/test_fspm_ctrl.sv ----
// Testbench for the self-programming mode control
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_fspm_ctrl;
	localparam logic [4:0] PB = 5'h16;
	logic                    clock;
	logic                    rstn;
	logic                    halt_req;
	logic                    halt_exec;
	logic                    flash_busy;
	logic                    mode_sel;
	logic                    flash_start;
	logic                    standby;
	logic                    halt_release;
	logic                    irq;
	logic [7:0]              f_cmd;
	logic [7:0]              f_data;
	logic [15:0]             f_addr;
	logic [31:0]             rd;
	logic                    err;
	fspm_pkg::fspm_apb_req_t req;
	fspm_pkg::fspm_apb_rsp_t rsp;
	int                      fail_count;
	int                      compares;
	int                      starts;
	int                      stbys;
	int                      cyc;
	fspm_ctrl #(.ENTRY_CYCLES(4), .OSC_CYCLES(3)) fspm_ctrl_inst (.clock(clock), .rstn(rstn), .clk_en(1'b1),
		.apb_req(req), .apb_rsp(rsp), .protect_byte(PB), .halt_exec(halt_exec), .flash_busy(flash_busy),
		.self_prog_mode_select(mode_sel), .flash_cmd(f_cmd), .flash_addr(f_addr), .flash_data(f_data),
		.flash_start(flash_start), .standby(standby), .halt_release(halt_release), .irq(irq));
	fspm_cpu fspm_cpu_inst (.clock(clock), .rstn(rstn), .halt_req(halt_req), .mode_sel(mode_sel),
		.flash_start(flash_start), .halt_exec(halt_exec), .flash_busy(flash_busy));
	// ********
	// Clock, counters, watchdog
	// ********
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		if (flash_start === 1'b1) starts++;
		if (standby === 1'b1) stbys++;
	end
	// Tests take well under 1000 cycles
	initial
	begin
		#100000;
		fail_count++;
		final_report;
	end
	task final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		do @(posedge clock); while (rsp.pready !== 1'b1 && ++n < 50);
		`CHECK_EQ("pready", 1'b1, rsp.pready)
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clock);
	endtask : xfer
	task prot(input logic [31:0] v1, input logic [31:0] v2, input logic [31:0] v3);
		xfer(1'b1, 12'h004, 32'h0000_00A5);
		xfer(1'b1, 12'h000, v1);
		xfer(1'b1, 12'h000, v2);
		xfer(1'b1, 12'h000, v3);
	endtask : prot
	task halt;
		halt_req <= 1'b1;
		@(posedge clock);
		halt_req <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : halt
	// ********
	// Main sequence
	// ********
	initial
	begin
		rstn = 1'b0;
		halt_req = 1'b0;
		req = '0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		xfer(1'b0, 12'h000, 0);
		`CHECK_EQ("mode", {24'h00_0000, 1'b0, PB, 2'h0}, rd)
		xfer(1'b1, 12'h000, 32'h0000_00FF);
		xfer(1'b0, 12'h000, 0);
		`CHECK_EQ("mode", {24'h00_0000, 1'b0, PB, 2'h0}, rd)
		xfer(1'b0, 12'h008, 0);
		`CHECK_EQ("status", 32'h0000_0001, rd)
		xfer(1'b1, 12'h014, 32'h0000_0001);
		`CHECK_EQ("irq", 1'b1, irq)
		xfer(1'b1, 12'h010, 32'h0000_0001);
		repeat (2) @(posedge clock);
		`CHECK_EQ("irq", 1'b0, irq)
		$display("done: registers");
		halt;
		`CHECK_EQ("standby", 1'b1, stbys > 0)
		prot(1, 1, 1);
		xfer(1'b0, 12'h000, 0);
		`CHECK_EQ("mode", 1'b0, rd[0])
		$display("done: normal mode");
		xfer(1'b1, 12'h00C, 0);
		xfer(1'b1, 12'h020, 1);
		prot(1, 0, 1);
		cyc = 0;
		while (halt_release !== 1'b1 && cyc < 100)
		begin
			@(posedge clock);
			cyc++;
		end
		`CHECK_EQ("entry", 1'b1, cyc >= 5 && cyc < 20)
		xfer(1'b0, 12'h000, 0);
		`CHECK_EQ("mode", 1'b1, rd[0])
		`CHECK_EQ("mode pin", 1'b1, mode_sel)
		xfer(1'b0, 12'h020, 0);
		`CHECK_EQ("ctrl", 32'h0000_0001, rd)
		xfer(1'b1, 12'h00C, 3);
		xfer(1'b1, 12'h018, 32'h0000_1234);
		xfer(1'b1, 12'h01C, 32'h0000_005A);
		halt;
		`CHECK_EQ("starts", 1, starts)
		`CHECK_EQ("op", 32'h0312_345A, {f_cmd, f_addr, f_data})
		xfer(1'b0, 12'h010, 0);
		`CHECK_EQ("irq status", 32'h0000_0003, rd)
		xfer(1'b0, 12'h3F0, 0);
		`CHECK_EQ("slverr", 1'b1, err)
		$display("done: self programming");
		xfer(1'b1, 12'h00C, 0);
		prot(0, 1, 0);
		xfer(1'b0, 12'h000, 0);
		`CHECK_EQ("mode", 1'b0, rd[0])
		`CHECK_EQ("mode pin", 1'b0, mode_sel)
		halt;
		`CHECK_EQ("starts", 1, starts)
		$display("done: exit");
		final_report;
	end
endmodule : test_fspm_ctrl
`default_nettype wire
